// *** include/diag_cfg_pkg.sv ***
// constants for the diagnostic configuration register bank
// assumes an apb slave with 32-bit data; register indices map to byte address index*4
// Notes on behaviour
// RQ1: overcurrent limit, 8 bits, resets a2
// RQ2: undercurrent limit, 8 bits, resets 48
// RQ3: aux analog upper limit, resets ba
// RQ4: aux analog lower limit, resets 4b
// RQ5: per-fault bit turns bias off on fault
// RQ6: recheck bit self clears, restores healthy channels
// RQ7: auto recovery enable lifts fault power-downs
// RQ8: short detect skipped while disable bit set
// RQ9: bias overvoltage margin, 3 bits, reset 2
// RQ10: input-to-bias margin, 3 bits, reset 2
// RQ11: input overvoltage margin, reset 1, codes 0-1
// RQ12: auto mode enables support channels with inputs
// RQ13: support channel bits count only when forced
// RQ14: supply and aux enables always direct
// RQ15: supply filter select, reset 2, four codes
// RQ16: battery filter select, same encoding
// RQ17: merge bit ors overvoltage and battery short
// RQ18: 12-bit result split high byte, nibble
// RQ19: channel id 0 battery, 1 bias
// RQ20: software writes reset value into reserved
// RQ21: input scan enables bit7 one, bit6 two
// RQ22: high and low result bytes update together
package diag_cfg_pkg;
	localparam logic [7:0] IDX_HIGH_CUR   = 8'h4c;
	localparam logic [7:0] IDX_LOW_CUR    = 8'h4d;
	localparam logic [7:0] IDX_AUX_UP     = 8'h4e;
	localparam logic [7:0] IDX_AUX_LOW    = 8'h4f;
	localparam logic [7:0] IDX_PD_CTRL    = 8'h50;
	localparam logic [7:0] IDX_BIAS_SB    = 8'h51;
	localparam logic [7:0] IDX_IN_SB      = 8'h52;
	localparam logic [7:0] IDX_CH_EN      = 8'h53;
	localparam logic [7:0] IDX_FILT       = 8'h54;
	localparam logic [7:0] IDX_BAT_HI     = 8'h56;
	localparam logic [7:0] IDX_BAT_LO     = 8'h57;
	localparam logic [7:0] IDX_BIAS_HI    = 8'h58;
	localparam logic [7:0] IDX_BIAS_LO    = 8'h59;
	localparam logic [7:0] IDX_IN_SCAN    = 8'h46;
	localparam logic [7:0] RST_HIGH_CUR   = 8'ha2;
	localparam logic [7:0] RST_LOW_CUR    = 8'h48;
	localparam logic [7:0] RST_AUX_UP     = 8'hba;
	localparam logic [7:0] RST_AUX_LOW    = 8'h4b;
	localparam logic [7:0] RST_PD_CTRL    = 8'h88;
	localparam logic [7:0] RST_BIAS_SB    = 8'h40;
	localparam logic [7:0] RST_IN_SB      = 8'h44;
	localparam logic [7:0] RST_CH_EN      = 8'h00;
	localparam logic [7:0] RST_FILT       = 8'h48;
	localparam logic [7:0] RST_IN_SCAN    = 8'h00;
	localparam logic [3:0] ID_BATTERY     = 4'h0;
	localparam logic [3:0] ID_BIAS        = 4'h1;
	// writable masks: reserved bits read zero and ignore writes
	localparam logic [7:0] MASK_BIAS_SB   = 8'he0;
	localparam logic [7:0] MASK_IN_SB     = 8'hfc;
	localparam logic [7:0] MASK_CH_EN     = 8'hfe;
	localparam logic [7:0] MASK_FILT      = 8'h6d;
	localparam logic [7:0] MASK_IN_SCAN   = 8'hc0;
	// field positions
	localparam int B_PD_SHORT = 7;
	localparam int B_PD_OVERCUR = 6;
	localparam int B_PD_UNDERCUR = 5;
	localparam int B_PD_OV = 4;
	localparam int B_PD_OT = 3;
	localparam int B_RECHECK = 2;
	localparam int B_AUTO_REC = 1;
	localparam int B_SHORT_OFF = 0;
	localparam int B_FORCE = 7;
	localparam int B_EN_LOAD = 6;
	localparam int B_EN_BIAS = 5;
	localparam int B_EN_BAT = 4;
	localparam int B_EN_TEMP = 3;
	localparam int B_EN_SUPPLY = 2;
	localparam int B_EN_AUX = 1;
	localparam int B_IN_ONE = 7;
	localparam int B_IN_TWO = 6;
	localparam int B_MERGE = 0;
	localparam int F_MARGIN_HI = 5;
	localparam int F_IN_OV_LO = 2;
	localparam int F_SUP_FILT = 5;
	localparam int F_BAT_FILT = 2;
	localparam logic [2:0] IN_OV_MARGIN_MAX = 3'h1;
	typedef enum logic [1:0] {
		FILT_3M5   = 2'b00,
		FILT_200K  = 2'b01,
		FILT_100K  = 2'b10,
		FILT_NONE  = 2'b11
	} filter_sel_t;
endpackage

// *** hw/result_pair.sv ***
// holds one monitor channel's 12-bit result and serves it as high byte and low nibble+id
// assumes the converter presents result and a one-cycle strobe on pclk
module result_pair
	import diag_cfg_pkg::*;
#(
	parameter logic [3:0] CHAN_ID = 4'h0
) (
	input  wire logic        pclk,       // clock
	input  wire logic        presetn,    // async reset, low
	input  wire logic        res_valid,  // new conversion strobe
	input  wire logic [11:0] res_data,   // conversion result
	output logic      [7:0]  high_byte,  // result bits 11:4
	output logic      [7:0]  low_byte    // bits 3:0 and id
);
	logic [11:0] result_ff;

	// RQ22 one update both bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_ff <= 12'h000;
		end else if (res_valid) begin
			result_ff <= res_data;
		end
	end

	// RQ18 split result
	assign high_byte = result_ff[11:4];
	// RQ19 constant id
	assign low_byte  = {result_ff[3:0], CHAN_ID};
endmodule // result_pair

// *** hw/diag_cfg_regs.sv ***
// apb register bank for bias fault thresholds, power-down reaction, recovery,
// safebands, channel enables, filter selection and the first monitor results
// assumes fault flags arrive from analog comparators asynchronously; results on pclk
//
// The APB slave port was decided locally.
module diag_cfg_regs
	import diag_cfg_pkg::*;
(
	input  wire logic        pclk,             // 250 MHz clock
	input  wire logic        presetn,          // async reset, low
	input  wire logic        psel,             // apb select
	input  wire logic        penable,          // apb access phase
	input  wire logic        pwrite,           // apb write
	input  wire logic [11:0] paddr,            // apb byte address
	input  wire logic [31:0] pwdata,           // apb write data
	input  wire logic [3:0]  pstrb,            // apb byte strobes
	output logic      [31:0] prdata,           // apb read data
	output logic             pready,           // apb ready
	output logic             pslverr,          // apb error
	input  wire logic        fault_short_raw,  // bias short comparator
	input  wire logic        fault_overcur_raw,// bias overcurrent comparator
	input  wire logic        fault_undercur_raw,// bias undercurrent comparator
	input  wire logic        fault_ov_raw,     // bias overvoltage comparator
	input  wire logic        fault_ot_raw,     // overtemperature comparator
	input  wire logic        in_ov_raw,        // input overvoltage comparator
	input  wire logic        in_bat_short_raw, // input short to battery
	input  wire logic        bat_res_valid,    // battery conversion strobe
	input  wire logic [11:0] bat_res_data,     // battery conversion
	input  wire logic        bias_res_valid,   // bias conversion strobe
	input  wire logic [11:0] bias_res_data,    // bias conversion
	output logic             bias_on,          // bias power enable
	output logic             short_detect_en,  // short detection active
	output logic [7:0]       bias_overcurrent_limit,   // threshold code
	output logic [7:0]       bias_undercurrent_limit,  // threshold code
	output logic [7:0]       aux_analog_upper_limit,   // threshold code
	output logic [7:0]       aux_analog_lower_limit,   // threshold code
	output logic [2:0]       bias_ov_margin,           // 30mV steps
	output logic [2:0]       input_to_bias_margin,     // 30mV steps
	output logic [2:0]       input_ov_margin,          // 0 or 30mV
	output logic             load_check_on,            // effective enable
	output logic             bias_check_on,            // effective enable
	output logic             battery_check_on,         // effective enable
	output logic             temp_check_on,            // effective enable
	output logic             analog_supply_check_en,   // supply enable
	output logic             aux_analog_check_en,      // aux channel enable
	output logic [1:0]       analog_supply_filter,     // filter code
	output logic [1:0]       battery_filter,           // filter code
	output logic             input_ov_fault,           // reported input ov
	output logic             battery_short_fault       // reported battery short
);
	logic [7:0] high_cur_ff, low_cur_ff, aux_up_ff, aux_low_ff;
	logic [7:0] pd_ctrl_ff, bias_sb_ff, in_sb_ff, ch_en_ff, filt_ff, in_scan_ff;
	logic [6:0] sync1_ff, sync2_ff;
	logic       bias_on_ff, ov_rep_ff, bs_rep_ff;
	logic [7:0] bat_hi, bat_lo, bias_hi, bias_lo;
	logic       wr_en, rd_phase, addr_ok, bias_fault;
	logic [9:0] idx;
	logic [7:0] wbyte, rbyte;

	assign idx      = paddr[11:2];
	assign wr_en    = psel && penable && pwrite && pstrb[0] && addr_ok && (paddr[1:0] == 2'b00);
	assign rd_phase = psel && penable;
	assign wbyte    = pwdata[7:0];
	assign pready   = 1'b1;

	function automatic logic [7:0] masked(input logic [7:0] old, input logic [7:0] nw, input logic [7:0] m);
		masked = (old & ~m) | (nw & m);
	endfunction

	always_comb begin
		addr_ok = 1'b1;
		rbyte   = 8'h00;
		unique case (idx[7:0] & {8{idx[9:8] == 2'b00}})
			IDX_HIGH_CUR: rbyte = high_cur_ff;
			IDX_LOW_CUR:  rbyte = low_cur_ff;
			IDX_AUX_UP:   rbyte = aux_up_ff;
			IDX_AUX_LOW:  rbyte = aux_low_ff;
			IDX_PD_CTRL:  rbyte = pd_ctrl_ff;
			IDX_BIAS_SB:  rbyte = bias_sb_ff;
			IDX_IN_SB:    rbyte = in_sb_ff;
			IDX_CH_EN:    rbyte = ch_en_ff;
			IDX_FILT:     rbyte = filt_ff;
			IDX_IN_SCAN:  rbyte = in_scan_ff;
			IDX_BAT_HI:   rbyte = bat_hi;
			IDX_BAT_LO:   rbyte = bat_lo;
			IDX_BIAS_HI:  rbyte = bias_hi;
			IDX_BIAS_LO:  rbyte = bias_lo;
			default:      addr_ok = 1'b0;
		endcase
		// a misaligned word is refused like an unmapped one, matching the write gate
		if (idx[9:8] != 2'b00 || paddr[1:0] != 2'b00) begin
			addr_ok = 1'b0;
		end
	end

	// unmapped addresses answer with an error and zero data
	assign pslverr = rd_phase && !addr_ok;
	assign prdata  = {24'h000000, rbyte};

	// RQ1 overcurrent threshold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) high_cur_ff <= RST_HIGH_CUR;
		else if (wr_en && idx == {2'b00, IDX_HIGH_CUR}) high_cur_ff <= wbyte;
	end
	// RQ2 undercurrent threshold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) low_cur_ff <= RST_LOW_CUR;
		else if (wr_en && idx == {2'b00, IDX_LOW_CUR}) low_cur_ff <= wbyte;
	end
	// RQ3 aux upper threshold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) aux_up_ff <= RST_AUX_UP;
		else if (wr_en && idx == {2'b00, IDX_AUX_UP}) aux_up_ff <= wbyte;
	end
	// RQ4 aux lower threshold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) aux_low_ff <= RST_AUX_LOW;
		else if (wr_en && idx == {2'b00, IDX_AUX_LOW}) aux_low_ff <= wbyte;
	end

	// RQ6 recheck self clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_ctrl_ff <= RST_PD_CTRL;
		end else if (wr_en && idx == {2'b00, IDX_PD_CTRL}) begin
			pd_ctrl_ff <= wbyte;
		end else begin
			pd_ctrl_ff[B_RECHECK] <= 1'b0;
		end
	end

	// RQ9 bias ov margin
	// RQ20 reserved bits held
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) bias_sb_ff <= RST_BIAS_SB;
		else if (wr_en && idx == {2'b00, IDX_BIAS_SB}) bias_sb_ff <= masked(bias_sb_ff, wbyte, MASK_BIAS_SB);
	end

	// RQ10 input-to-bias margin
	// RQ11 input ov margin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) in_sb_ff <= RST_IN_SB;
		else if (wr_en && idx == {2'b00, IDX_IN_SB}) in_sb_ff <= masked(in_sb_ff, wbyte, MASK_IN_SB);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ch_en_ff <= RST_CH_EN;
		else if (wr_en && idx == {2'b00, IDX_CH_EN}) ch_en_ff <= masked(ch_en_ff, wbyte, MASK_CH_EN);
	end

	// RQ15 supply filter
	// RQ16 battery filter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) filt_ff <= RST_FILT;
		else if (wr_en && idx == {2'b00, IDX_FILT}) filt_ff <= masked(filt_ff, wbyte, MASK_FILT);
	end

	// RQ21 input scan enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) in_scan_ff <= RST_IN_SCAN;
		else if (wr_en && idx == {2'b00, IDX_IN_SCAN}) in_scan_ff <= masked(in_scan_ff, wbyte, MASK_IN_SCAN);
	end

	// comparator flags are asynchronous: two flops before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= 7'h00;
			sync2_ff <= 7'h00;
		end else begin
			sync1_ff <= {in_bat_short_raw, in_ov_raw, fault_ot_raw, fault_ov_raw,
				fault_undercur_raw, fault_overcur_raw, fault_short_raw};
			sync2_ff <= sync1_ff;
		end
	end

	// RQ8 short detect gating
	// RQ5 per-fault power-down
	assign bias_fault = (sync2_ff[0] && !pd_ctrl_ff[B_SHORT_OFF] && pd_ctrl_ff[B_PD_SHORT])
		|| (sync2_ff[1] && pd_ctrl_ff[B_PD_OVERCUR])
		|| (sync2_ff[2] && pd_ctrl_ff[B_PD_UNDERCUR])
		|| (sync2_ff[3] && pd_ctrl_ff[B_PD_OV])
		|| (sync2_ff[4] && pd_ctrl_ff[B_PD_OT]);

	// a fault in the same cycle as a recovery wins, so bias never
	// powers up into a condition still present
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bias_on_ff <= 1'b1;
		end else if (bias_fault) begin
			bias_on_ff <= 1'b0;
		// RQ7 automatic recovery
		end else if (pd_ctrl_ff[B_AUTO_REC]) begin
			bias_on_ff <= 1'b1;
		// RQ6 manual recheck
		end else if (pd_ctrl_ff[B_RECHECK]) begin
			bias_on_ff <= 1'b1;
		end
	end

	// RQ17 merge battery short
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ov_rep_ff <= 1'b0;
			bs_rep_ff <= 1'b0;
		end else if (filt_ff[B_MERGE]) begin
			ov_rep_ff <= 1'b0;
			bs_rep_ff <= sync2_ff[5] | sync2_ff[6];
		end else begin
			ov_rep_ff <= sync2_ff[5];
			bs_rep_ff <= sync2_ff[6];
		end
	end

	result_pair #(.CHAN_ID(ID_BATTERY)) u_bat (
		.pclk      (pclk),
		.presetn   (presetn),
		.res_valid (bat_res_valid),
		.res_data  (bat_res_data),
		.high_byte (bat_hi),
		.low_byte  (bat_lo)
	);

	result_pair #(.CHAN_ID(ID_BIAS)) u_bias (
		.pclk      (pclk),
		.presetn   (presetn),
		.res_valid (bias_res_valid),
		.res_data  (bias_res_data),
		.high_byte (bias_hi),
		.low_byte  (bias_lo)
	);

	assign bias_on                 = bias_on_ff;
	assign short_detect_en         = !pd_ctrl_ff[B_SHORT_OFF];
	assign bias_overcurrent_limit  = high_cur_ff;
	assign bias_undercurrent_limit = low_cur_ff;
	assign aux_analog_upper_limit  = aux_up_ff;
	assign aux_analog_lower_limit  = aux_low_ff;
	assign bias_ov_margin          = bias_sb_ff[F_MARGIN_HI +: 3];
	assign input_to_bias_margin    = in_sb_ff[F_MARGIN_HI +: 3];
	// codes above one are unsupported, so clamp rather than pass them on
	assign input_ov_margin = (in_sb_ff[F_IN_OV_LO +: 3] > IN_OV_MARGIN_MAX) ? IN_OV_MARGIN_MAX
		: in_sb_ff[F_IN_OV_LO +: 3];

	// RQ12 auto channel enable
	// RQ13 manual enables when forced
	always_comb begin
		logic any_in;
		any_in = in_scan_ff[B_IN_ONE] | in_scan_ff[B_IN_TWO];
		if (ch_en_ff[B_FORCE]) begin
			load_check_on    = ch_en_ff[B_EN_LOAD];
			bias_check_on    = ch_en_ff[B_EN_BIAS];
			battery_check_on = ch_en_ff[B_EN_BAT];
			temp_check_on    = ch_en_ff[B_EN_TEMP];
		end else begin
			load_check_on    = any_in;
			bias_check_on    = any_in;
			battery_check_on = any_in;
			temp_check_on    = any_in;
		end
	end

	// RQ14 direct enables
	assign analog_supply_check_en = ch_en_ff[B_EN_SUPPLY];
	assign aux_analog_check_en    = ch_en_ff[B_EN_AUX];
	assign analog_supply_filter   = filt_ff[F_SUP_FILT +: 2];
	assign battery_filter         = filt_ff[F_BAT_FILT +: 2];
	assign input_ov_fault         = ov_rep_ff;
	assign battery_short_fault    = bs_rep_ff;
endmodule // diag_cfg_regs

// *** dv/diag_cfg_regs_properties.sv ***
// port-level checks of the diagnostic register bank
// assumes binding into diag_cfg_regs; sees only its ports
module diag_cfg_regs_checker
	import diag_cfg_pkg::*;
(
	input wire logic        pclk,               // clock
	input wire logic        presetn,            // async reset, low
	input wire logic        psel,               // apb select
	input wire logic        penable,            // apb access
	input wire logic        pwrite,             // apb write
	input wire logic [11:0] paddr,              // apb address
	input wire logic [31:0] prdata,             // apb read data
	input wire logic        pready,             // apb ready
	input wire logic        pslverr,            // apb error
	input wire logic        fault_short_raw,    // short comparator
	input wire logic        fault_overcur_raw,  // overcurrent comparator
	input wire logic        fault_undercur_raw, // undercurrent comparator
	input wire logic        fault_ov_raw,       // overvoltage comparator
	input wire logic        fault_ot_raw,       // overtemp comparator
	input wire logic        bias_res_valid,     // bias strobe
	input wire logic [11:0] bias_res_data,      // bias result
	input wire logic        bias_on,            // bias enable
	input wire logic [2:0]  input_ov_margin     // input ov margin
);
	logic       rd_acc;
	logic       any_fault;
	logic [7:0] res_hi;
	assign rd_acc = psel && penable && !pwrite;
	assign res_hi = bias_res_data[11:4];
	assign any_fault = fault_short_raw | fault_overcur_raw | fault_undercur_raw | fault_ov_raw | fault_ot_raw;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_ready; psel && penable |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("access phase without ready");
	property p_hi_zero; rd_acc |-> prdata[31:8] == 24'h0; endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("upper read bits not zero");
	property p_refuse; psel && penable && paddr[1:0] != 2'b00 |-> pslverr; endproperty
	a_refuse: assert property (p_refuse) else $error("misaligned access not refused");
	// bias may only drop two or three edges after a comparator raised a fault
	property p_drop; $fell(bias_on) |-> $past(any_fault, 2) || $past(any_fault, 3); endproperty
	a_drop: assert property (p_drop) else $error("bias dropped without fault");
	property p_pair;
		bias_res_valid ##1 (rd_acc && paddr == {2'b00, IDX_BIAS_HI, 2'b00}) |-> prdata[7:0] == $past(res_hi);
	endproperty
	a_pair: assert property (p_pair) else $error("high byte not from latest conversion");
	property p_bias_id; rd_acc && paddr == {2'b00, IDX_BIAS_LO, 2'b00} |-> prdata[3:0] == ID_BIAS; endproperty
	a_bias_id: assert property (p_bias_id) else $error("bias channel id wrong");
	property p_bat_id; rd_acc && paddr == {2'b00, IDX_BAT_LO, 2'b00} |-> prdata[3:0] == ID_BATTERY; endproperty
	a_bat_id: assert property (p_bat_id) else $error("battery channel id wrong");
	property p_clamp; input_ov_margin <= IN_OV_MARGIN_MAX; endproperty
	a_clamp: assert property (p_clamp) else $error("input ov margin above one step");
	c_drop: cover property ($fell(bias_on));
	c_refuse: cover property (psel && penable && pslverr);
	c_pair: cover property (bias_res_valid ##1 rd_acc);
endmodule // diag_cfg_regs_checker

bind diag_cfg_regs diag_cfg_regs_checker u_checker (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .fault_short_raw,
	.fault_overcur_raw, .fault_undercur_raw, .fault_ov_raw, .fault_ot_raw, .bias_res_valid, .bias_res_data,
	.bias_on, .input_ov_margin
);

// *** dv/diag_cfg_regs_tb_top.sv ***
// self-checking bench for the diagnostic register bank
// assumes diag_cfg_regs alone, apb and comparator inputs driven from here
module diag_cfg_regs_tb_top import diag_cfg_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        in_ov_raw = 1'b0, in_bat_short_raw = 1'b0, bat_res_valid = 1'b0, bias_res_valid = 1'b0;
	logic [11:0] paddr = 12'h000, bat_res_data = 12'h000, bias_res_data = 12'h000, r;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0]  pstrb = 4'hf;
	logic [4:0]  flt = 5'h00;
	logic [7:0]  bias_overcurrent_limit, d, d2;
	logic [7:0]  bias_undercurrent_limit, aux_analog_upper_limit, aux_analog_lower_limit;
	logic [2:0]  bias_ov_margin, input_to_bias_margin, input_ov_margin;
	logic [1:0]  analog_supply_filter, battery_filter;
	logic        pready, pslverr, err, bias_on, short_detect_en, input_ov_fault, battery_short_fault;
	logic        load_check_on, bias_check_on, battery_check_on, temp_check_on;
	logic        analog_supply_check_en, aux_analog_check_en;
	int          seed = 27, num_errors = 0, check_count = 0, k;
	logic [7:0]  ri [14] = '{IDX_HIGH_CUR, IDX_LOW_CUR, IDX_AUX_UP, IDX_AUX_LOW, IDX_PD_CTRL, IDX_BIAS_SB,
		IDX_IN_SB, IDX_CH_EN, IDX_FILT, IDX_BAT_HI, IDX_BAT_LO, IDX_BIAS_HI, IDX_BIAS_LO, IDX_IN_SCAN};
	logic [7:0]  rv [14] = '{RST_HIGH_CUR, RST_LOW_CUR, RST_AUX_UP, RST_AUX_LOW, RST_PD_CTRL, RST_BIAS_SB,
		RST_IN_SB, RST_CH_EN, RST_FILT, 8'h00, {4'h0, ID_BATTERY}, 8'h00, {4'h0, ID_BIAS}, RST_IN_SCAN};
	// input ov margin limited to codes 0 and 1, reserved bits kept at zero
	logic [7:0]  wm [10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hfb, MASK_BIAS_SB, 8'he4, MASK_CH_EN, MASK_FILT,
		MASK_IN_SCAN};

	diag_cfg_regs dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.fault_short_raw(flt[4]), .fault_overcur_raw(flt[3]), .fault_undercur_raw(flt[2]),
		.fault_ov_raw(flt[1]), .fault_ot_raw(flt[0]), .in_ov_raw, .in_bat_short_raw,
		.bat_res_valid, .bat_res_data, .bias_res_valid, .bias_res_data, .bias_on, .short_detect_en,
		.bias_overcurrent_limit, .bias_undercurrent_limit, .aux_analog_upper_limit,
		.aux_analog_lower_limit, .bias_ov_margin, .input_to_bias_margin, .input_ov_margin,
		.load_check_on, .bias_check_on, .battery_check_on, .temp_check_on, .analog_supply_check_en,
		.aux_analog_check_en, .analog_supply_filter, .battery_filter, .input_ov_fault, .battery_short_fault
	);

	initial begin
		forever #2 pclk = ~pclk;
	end

	function automatic logic [11:0] ba(input logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction

	// forced mode obeys the bits, auto mode follows any input scan
	function automatic logic [5:0] exp_en(input logic [7:0] c, input logic [7:0] s);
		return c[7] ? {c[6:3], c[2:1]} : {{4{|s[7:6]}}, c[2:1]};
	endfunction

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, s, e);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// ends one idle edge after release so the next request never lands in the same step
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		bat_res_valid <= 1'b0;
		bias_res_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			num_errors++;
			print_verdict();
		end
		@(posedge pclk);
	endtask

	task automatic rdc(input logic [7:0] i, input logic [7:0] e);
		apb(1'b0, ba(i), 8'h00);
		chk(rd, {24'h0, e});
		chk(err, 1'b0);
	endtask

	initial begin
		cyc(10);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 14; i++)
			rdc(ri[i], rv[i]);
		chk({bias_undercurrent_limit, aux_analog_upper_limit, aux_analog_lower_limit},
			{8'h00, RST_LOW_CUR, RST_AUX_UP, RST_AUX_LOW});
		chk({bias_ov_margin, input_to_bias_margin, input_ov_margin}, {3'h2, 3'h2, 3'h1});
		chk(bias_on, 1'b1);
		for (int i = 0; i < 40; i++) begin
			k = int'({$random(seed)} % 10);
			d = 8'($random(seed)) & wm[k];
			apb(1'b1, ba(k < 9 ? ri[k] : IDX_IN_SCAN), d);
			rdc(k < 9 ? ri[k] : IDX_IN_SCAN, d);
		end
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, ba(IDX_FILT), {1'b0, c[1:0], 1'b0, 2'(3 - c), 2'b00});
			chk({analog_supply_filter, battery_filter}, {c[1:0], 2'(3 - c)});
		end
		apb(1'b1, ba(IDX_BIAS_SB), 8'he0);
		apb(1'b1, ba(IDX_IN_SB), 8'ha0);
		chk({bias_ov_margin, input_to_bias_margin, input_ov_margin}, {3'h7, 3'h5, 3'h0});
		apb(1'b1, ba(IDX_HIGH_CUR), 8'h5a);
		// a write without its byte strobe must leave the register alone
		pstrb <= 4'h0;
		apb(1'b1, ba(IDX_HIGH_CUR), 8'h33);
		pstrb <= 4'hf;
		apb(1'b1, ba(IDX_HIGH_CUR) + 12'h001, 8'h11);
		chk(err, 1'b1);
		chk(bias_overcurrent_limit, 8'h5a);
		apb(1'b0, ba(8'h55), 8'h00);
		chk(err, 1'b1);
		apb(1'b1, ba(IDX_BIAS_LO), 8'hff);
		rdc(IDX_BIAS_LO, {4'h0, ID_BIAS});
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, ba(IDX_PD_CTRL), 8'h02 | (8'h08 << i));
			flt <= 5'h01 << i;
			cyc(5);
			chk(bias_on, 1'b0);
			flt <= 5'h00;
			cyc(5);
			chk(bias_on, 1'b1);
		end
		apb(1'b1, ba(IDX_PD_CTRL), 8'h02);
		flt <= 5'h1f;
		cyc(5);
		chk(bias_on, 1'b1);
		flt <= 5'h00;
		apb(1'b1, ba(IDX_PD_CTRL), 8'h83);
		chk(short_detect_en, 1'b0);
		flt <= 5'h10;
		cyc(5);
		chk(bias_on, 1'b1);
		flt <= 5'h00;
		apb(1'b1, ba(IDX_PD_CTRL), 8'h40);
		chk(short_detect_en, 1'b1);
		flt <= 5'h08;
		cyc(5);
		flt <= 5'h00;
		cyc(5);
		chk(bias_on, 1'b0);
		apb(1'b1, ba(IDX_PD_CTRL), 8'h44);
		cyc(2);
		chk(bias_on, 1'b1);
		rdc(IDX_PD_CTRL, 8'h40);
		for (int i = 0; i < 24; i++) begin
			d = 8'($random(seed)) & MASK_CH_EN;
			d2 = 8'($random(seed)) & MASK_IN_SCAN;
			apb(1'b1, ba(IDX_CH_EN), d);
			apb(1'b1, ba(IDX_IN_SCAN), d2);
			chk({load_check_on, bias_check_on, battery_check_on, temp_check_on, analog_supply_check_en,
				aux_analog_check_en}, exp_en(d, d2));
		end
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, ba(IDX_FILT), RST_FILT | {7'h00, i[2]});
			in_ov_raw <= i[0];
			in_bat_short_raw <= i[1];
			cyc(5);
			chk({input_ov_fault, battery_short_fault}, i[2] ? {1'b0, |i[1:0]} : {i[0], i[1]});
		end
		for (int i = 0; i < 8; i++) begin
			r = 12'($random(seed));
			bias_res_data <= r;
			bias_res_valid <= i[0];
			bat_res_data <= r;
			bat_res_valid <= !i[0];
			apb(1'b0, ba(i[0] ? IDX_BIAS_HI : IDX_BAT_HI), 8'h00);
			chk(rd, {24'h0, r[11:4]});
			rdc(i[0] ? IDX_BIAS_LO : IDX_BAT_LO, {r[3:0], i[0] ? ID_BIAS : ID_BATTERY});
		end
		print_verdict();
	end
endmodule // diag_cfg_regs_tb_top
